// >>> dior_pkg.sv
// Purpose: Shared constants for the digital I/O port and pin routing block.
// Assumes: Registers reached over the MPU special-function and I/O RAM byte space.
// Notes: Offsets are byte addresses of that space; fields are bit positions.
package dior_pkg;
   localparam int ADDR_W = 16;
   localparam logic [15:0] OFS_DATA_LOW = 16'h0080;
   localparam logic [15:0] OFS_DATA_MID = 16'h0090;
   localparam logic [15:0] OFS_DIR_MID = 16'h0091;
   localparam logic [15:0] OFS_DATA_P17 = 16'h00a0;
   localparam logic [15:0] OFS_DIR_P17 = 16'h00a1;
   localparam logic [15:0] OFS_DIR_LOW = 16'h00a2;
   localparam logic [15:0] OFS_DATA_HIGH = 16'h00b0;
   localparam logic [15:0] OFS_COMP_STAT = 16'h2003;
   localparam logic [15:0] OFS_CKOUT_SEL = 16'h2004;
   localparam logic [15:0] OFS_ROUTE_0 = 16'h2009;
   localparam logic [15:0] OFS_ROUTE_1 = 16'h200a;
   localparam logic [15:0] OFS_ROUTE_2 = 16'h200b;
   localparam logic [15:0] OFS_ROUTE_3 = 16'h200c;
   localparam logic [15:0] OFS_ROUTE_4 = 16'h200d;
   localparam logic [15:0] OFS_ROUTE_5 = 16'h200e;
   localparam int BIT_P17 = 1;
   localparam int BIT_CKOUT = 4;
   localparam int BIT_COMP = 0;
   localparam int LO_FIELD = 0;
   localparam int HI_FIELD = 4;
   localparam int BIT_HIGH_PAIR = 4;
   localparam int NUM_ROUTE = 10;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RT_NONE = 3'h0;
   localparam logic [2:0] RT_RSVD = 3'h1;
   localparam logic [2:0] RT_T0 = 3'h2;
   localparam logic [2:0] RT_T1 = 3'h3;
   localparam logic [2:0] RT_HI_RISE = 3'h4;
   localparam logic [2:0] RT_LO_RISE = 3'h5;
   localparam logic [2:0] RT_HI_FALL = 3'h6;
   localparam logic [2:0] RT_LO_FALL = 3'h7;
endpackage

// >>> dior_router.sv
// Purpose: Routes selected input pins onto timer inputs and interrupt edge pulses.
// Assumes: Pin levels are synchronous to ref_clk.
// Notes: Edge pulses are one cycle wide, one cycle after the pin changes.
`timescale 1ns/1ns
module dior_router #(
   parameter int N = 10
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [N-1:0] pin_in,
   input wire logic [3*N-1:0] route_fields,
   output logic timer_zero_clock_gate,
   output logic timer_one_clock_gate,
   output logic high_priority_io_interrupt,
   output logic low_priority_io_interrupt
);
   import dior_pkg::*;

   typedef struct packed {
      logic [N-1:0] prev;
      logic t0;
      logic t1;
      logic hi;
      logic lo;
   } dior_rt_state_t;

   dior_rt_state_t st_r;
   dior_rt_state_t st_nxt;

   // Decode of one field against one code, shared by every resource.
   function automatic logic sel(input logic [3*N-1:0] f, input int i, input logic [2:0] c);
      sel = (f[3*i +: 3] == c);
   endfunction

   // Every source matching a resource is ORed in; reserved code drives nothing.
   always_comb begin
      st_nxt = st_r;
      st_nxt.prev = pin_in;
      st_nxt.t0 = 1'b0;
      st_nxt.t1 = 1'b0;
      st_nxt.hi = 1'b0;
      st_nxt.lo = 1'b0;
      for (int i = 0; i < N; i++) begin
         st_nxt.t0 = st_nxt.t0 | (sel(route_fields, i, RT_T0) & pin_in[i]);
         st_nxt.t1 = st_nxt.t1 | (sel(route_fields, i, RT_T1) & pin_in[i]);
         st_nxt.hi = st_nxt.hi | (sel(route_fields, i, RT_HI_RISE) & pin_in[i] & ~st_r.prev[i])
            | (sel(route_fields, i, RT_HI_FALL) & ~pin_in[i] & st_r.prev[i]);
         st_nxt.lo = st_nxt.lo | (sel(route_fields, i, RT_LO_RISE) & pin_in[i] & ~st_r.prev[i])
            | (sel(route_fields, i, RT_LO_FALL) & ~pin_in[i] & st_r.prev[i]);
      end
      if (srst) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_r <= st_nxt;
   end

   assign timer_zero_clock_gate = st_r.t0;
   assign timer_one_clock_gate = st_r.t1;
   assign high_priority_io_interrupt = st_r.hi;
   assign low_priority_io_interrupt = st_r.lo;

   // A routed rising edge must reach the high-priority interrupt one cycle later.
   a_hi_rise_edge: assert property (@(posedge ref_clk) disable iff (srst)
      (route_fields[2:0] == RT_HI_RISE && pin_in[0] && !st_r.prev[0]) |=> high_priority_io_interrupt)
      else $error("rising edge not routed to high interrupt");
   // A timer-zero route follows the pin level.
   a_t0_follow: assert property (@(posedge ref_clk) disable iff (srst)
      (route_fields[2:0] == RT_T0 && pin_in[0]) |=> timer_zero_clock_gate)
      else $error("timer zero does not follow routed pin");
   // With every field at the no-route code, the timer-one input stays low.
   a_t1_idle: assert property (@(posedge ref_clk) disable iff (srst)
      (route_fields == '0) |=> !timer_one_clock_gate)
      else $error("timer one driven with no route");
   // A routed falling edge reaches the low-priority interrupt.
   a_lo_fall_edge: assert property (@(posedge ref_clk) disable iff (srst)
      (route_fields[2:0] == RT_LO_FALL && !pin_in[0] && st_r.prev[0]) |=> low_priority_io_interrupt)
      else $error("falling edge not routed to low interrupt");
endmodule

// >>> dior_top.sv
// Purpose: Digital I/O port registers, pin drivers, routing and clock-out pin select.
// Assumes: A simple byte register port: addr, wdata, wr_en, rd_en, one-cycle read data.
// Notes: Pins not in GPIO use ignore direction and data writes toward the pin.
`timescale 1ns/1ns
module dior_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [dior_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] pin_in,
   input wire logic pin17_in,
   input wire logic [1:0] pin_pair_in,
   input wire logic push_button_input,
   input wire logic [15:0] pin_lcd_mode,
   input wire logic [1:0] pin_pair_lcd_mode,
   input wire logic pin17_lcd_mode,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   output logic pin17_out,
   output logic pin17_oe,
   output logic [1:0] pin_pair_out,
   output logic [1:0] pin_pair_oe,
   input wire logic supply_comparator_good,
   input wire logic lcd_segment_nineteen,
   input wire logic decimation_filter_clock,
   output logic lcd_segment_nineteen_pin_out,
   output logic timer_zero_clock_gate,
   output logic timer_one_clock_gate,
   output logic high_priority_io_interrupt,
   output logic low_priority_io_interrupt
);
   import dior_pkg::*;

   typedef struct packed {
      logic [7:0] data_low;
      logic [7:0] data_mid;
      logic data_p17;
      logic [1:0] data_pair;
      logic [7:1] dir_low;
      logic [7:0] dir_mid;
      logic dir_p17;
      logic ckout_sel;
      logic [3*NUM_ROUTE-1:0] route;
      logic [7:0] rdata;
   } dior_state_t;

   dior_state_t st_r;
   dior_state_t st_nxt;
   logic [15:0] dir_all;
   logic [15:0] data_all;
   logic [15:0] out_pins;
   logic [NUM_ROUTE-1:0] route_src;

   // Up to two route fields share each byte: low field at bit 0, high at bit 4.
   function automatic logic [7:0] pack_pair(input logic [2:0] lo, input logic [2:0] hi);
      pack_pair = {1'b0, hi, 1'b0, lo};
   endfunction

   // Merge a written data byte: only GPIO outputs take the new bit.
   function automatic logic [7:0] merge_data(input logic [7:0] old, input logic [7:0] wd,
                                             input logic [7:0] dir, input logic [7:0] lcd);
      merge_data = (wd & dir & ~lcd) | (old & ~(dir & ~lcd));
   endfunction

   // Route field of byte j, half h. Pin 2 owns its byte alone and the last high half
   // is empty, so those two halves hold no field and read back as zero.
   function automatic logic field_ok(input int j, input int h);
      field_ok = !(j == 1 && h == 1) && ((j < 2 ? 2 * j + h : 2 * j + h - 1) < NUM_ROUTE);
   endfunction

   // Field index is clamped to zero for empty halves so no select leaves the vector.
   function automatic int field_idx(input int j, input int h);
      field_idx = field_ok(j, h) ? (j < 2 ? 2 * j + h : 2 * j + h - 1) : 0;
   endfunction

   // Read back one route field, or the no-route code for an empty half.
   function automatic logic [2:0] field_get(input logic [3*NUM_ROUTE-1:0] r, input int j,
                                            input int h);
      field_get = field_ok(j, h) ? r[3*field_idx(j, h) +: 3] : RT_NONE;
   endfunction

   // Direction vector over pins 15..0; pin 0 carries no direction.
   assign dir_all = {st_r.dir_mid, st_r.dir_low, 1'b0};
   assign data_all = {st_r.data_mid, st_r.data_low[7:1], 1'b0};
   assign out_pins = dir_all & ~pin_lcd_mode;

   // Register write and read decode, with data reads returning live pin levels.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = RST_BYTE;
      if (reg_wr_en) begin
         if (reg_addr == OFS_DATA_LOW) begin
            st_nxt.data_low = merge_data(st_r.data_low, reg_wdata, {dir_all[7:1], 1'b0},
               pin_lcd_mode[7:0]);
         end else if (reg_addr == OFS_DATA_MID) begin
            st_nxt.data_mid = merge_data(st_r.data_mid, reg_wdata, st_r.dir_mid,
               pin_lcd_mode[15:8]);
         end else if (reg_addr == OFS_DIR_MID) begin
            st_nxt.dir_mid = reg_wdata;
         end else if (reg_addr == OFS_DATA_P17) begin
            if (st_r.dir_p17 && !pin17_lcd_mode) begin
               st_nxt.data_p17 = reg_wdata[BIT_P17];
            end
         end else if (reg_addr == OFS_DIR_P17) begin
            st_nxt.dir_p17 = reg_wdata[BIT_P17];
         end else if (reg_addr == OFS_DIR_LOW) begin
            st_nxt.dir_low = reg_wdata[7:1];
         end else if (reg_addr == OFS_DATA_HIGH) begin
            // The pair has no own direction bits; it drives unless in LCD use.
            for (int k = 0; k < 2; k++) begin
               if (!pin_pair_lcd_mode[k]) begin
                  st_nxt.data_pair[k] = reg_wdata[BIT_HIGH_PAIR + k];
               end
            end
         end else if (reg_addr == OFS_CKOUT_SEL) begin
            st_nxt.ckout_sel = reg_wdata[BIT_CKOUT];
         end else if (reg_addr >= OFS_ROUTE_0 && reg_addr <= OFS_ROUTE_5) begin
            for (int j = 0; j <= int'(OFS_ROUTE_5 - OFS_ROUTE_0); j++) begin
               if (reg_addr == OFS_ROUTE_0 + 16'(j)) begin
                  for (int h = 0; h < 2; h++) begin
                     if (field_ok(j, h)) begin
                        st_nxt.route[3*field_idx(j, h) +: 3] =
                           reg_wdata[(h == 0 ? LO_FIELD : HI_FIELD) +: 3];
                     end
                  end
               end
            end
         end
      end
      if (reg_rd_en) begin
         if (reg_addr == OFS_DATA_LOW) begin
            st_nxt.rdata = {pin_in[7:1], push_button_input};
         end else if (reg_addr == OFS_DATA_MID) begin
            st_nxt.rdata = pin_in[15:8];
         end else if (reg_addr == OFS_DIR_MID) begin
            st_nxt.rdata = st_r.dir_mid;
         end else if (reg_addr == OFS_DATA_P17) begin
            st_nxt.rdata = 8'(pin17_in) << BIT_P17;
         end else if (reg_addr == OFS_DIR_P17) begin
            st_nxt.rdata = 8'(st_r.dir_p17) << BIT_P17;
         end else if (reg_addr == OFS_DIR_LOW) begin
            st_nxt.rdata = {st_r.dir_low, 1'b0};
         end else if (reg_addr == OFS_DATA_HIGH) begin
            st_nxt.rdata = 8'(pin_pair_in) << BIT_HIGH_PAIR;
         end else if (reg_addr == OFS_COMP_STAT) begin
            st_nxt.rdata = 8'(supply_comparator_good) << BIT_COMP;
         end else if (reg_addr == OFS_CKOUT_SEL) begin
            st_nxt.rdata = 8'(st_r.ckout_sel) << BIT_CKOUT;
         end else if (reg_addr >= OFS_ROUTE_0 && reg_addr <= OFS_ROUTE_5) begin
            for (int j = 0; j <= int'(OFS_ROUTE_5 - OFS_ROUTE_0); j++) begin
               if (reg_addr == OFS_ROUTE_0 + 16'(j)) begin
                  st_nxt.rdata = pack_pair(field_get(st_r.route, j, 0),
                     field_get(st_r.route, j, 1));
               end
            end
         end
      end
      if (srst) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge ref_clk) begin
      st_r <= st_nxt;
   end

   // Pin drivers: enabled only for GPIO outputs.
   assign pin_oe = out_pins;
   assign pin_out = data_all & out_pins;
   assign pin17_oe = st_r.dir_p17 & ~pin17_lcd_mode;
   assign pin17_out = st_r.data_p17 & pin17_oe;
   assign pin_pair_oe = ~pin_pair_lcd_mode;
   assign pin_pair_out = st_r.data_pair & ~pin_pair_lcd_mode;
   assign reg_rdata = st_r.rdata;

   // The filter clock rate (fast or slow in low-power state) is set upstream.
   assign lcd_segment_nineteen_pin_out = st_r.ckout_sel ? decimation_filter_clock
                                         : lcd_segment_nineteen;

   // Route sources, field order: push button, pin 1, pin 2 (own byte), then pins 4..10.
   assign route_src = {pin_in[10:4], pin_in[2], pin_in[1], push_button_input};

   dior_router #(
      .N(NUM_ROUTE)
   ) u_router (
      .ref_clk(ref_clk),
      .srst(srst),
      .pin_in(route_src),
      .route_fields(st_r.route),
      .timer_zero_clock_gate(timer_zero_clock_gate),
      .timer_one_clock_gate(timer_one_clock_gate),
      .high_priority_io_interrupt(high_priority_io_interrupt),
      .low_priority_io_interrupt(low_priority_io_interrupt)
   );

   a_ckout_mux: assert property (@(posedge ref_clk) disable iff (srst)
      lcd_segment_nineteen_pin_out == (st_r.ckout_sel ? decimation_filter_clock : lcd_segment_nineteen))
      else $error("shared pin source wrong");
   a_comp_read: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_rd_en && reg_addr == OFS_COMP_STAT) |=> reg_rdata[0] == $past(supply_comparator_good))
      else $error("comparator status not mirrored");
   a_dir_low_wr: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr_en && reg_addr == OFS_DIR_LOW) |=> dir_all[7:1] == $past(reg_wdata[7:1]))
      else $error("low direction write lost");
   a_lcd_no_drive: assert property (@(posedge ref_clk) disable iff (srst)
      (pin_oe & pin_lcd_mode) == 16'h0000)
      else $error("lcd pin driven as gpio");
   a_dir_mid_wr: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr_en && reg_addr == OFS_DIR_MID) |=> dir_all[15:8] == $past(reg_wdata))
      else $error("mid direction write lost");
   a_p17_dir: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr_en && reg_addr == OFS_DIR_P17) |=> st_r.dir_p17 == $past(reg_wdata[1]))
      else $error("pin17 direction write lost");
   a_input_ignores: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_wr_en && reg_addr == OFS_DATA_MID && st_r.dir_mid == 8'h00) |=> $stable(st_r.data_mid))
      else $error("input pin took data write");
   a_pair_read: assert property (@(posedge ref_clk) disable iff (srst)
      (reg_rd_en && reg_addr == OFS_DATA_HIGH) |=> reg_rdata[5:4] == $past(pin_pair_in))
      else $error("pair read misplaced");
   a_reset_input: assert property (@(posedge ref_clk)
      srst |=> (pin_oe == 16'h0000 && !pin17_oe))
      else $error("pins not inputs after reset");
endmodule

// >>> dior_far_side.sv
// Purpose: Far side of the port: pin wires, timer inputs and interrupt inputs.
// Assumes: Pins that the port does not drive follow the levels the bench asks for.
// Notes: Counts are cleared by the bench before each routing run.
`timescale 1ns/1ns
module dior_far_side (
   input wire logic ref_clk,
   input wire logic cnt_clr,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] ext_lvl,
   output logic [15:0] pin_in,
   input wire logic [3:0] evt,
   output int evt_count [4]
);
   // A driven pin shows the port's level; an undriven one shows the outside world.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);

   // Sample timer levels and interrupt pulses the way the timers and the MPU would.
   initial begin
      for (int i = 0; i < 4; i++) evt_count[i] = 0;
   end
   always @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         evt_count[i] <= cnt_clr ? 0 : evt_count[i] + (evt[i] === 1'b1 ? 1 : 0);
      end
   end
endmodule

// >>> test_digital_io_port_routing.sv
// Purpose: Self-checking bench for the digital I/O port and pin routing block.
// Assumes: One-cycle register reads and registered routed outputs as handed over.
// Notes: Data and lcd modes come from an LFSR so that masks vary between runs of a loop.
`timescale 1ns/1ns
module test_digital_io_port_routing;
   import dior_pkg::*;
   logic ref_clk, srst, reg_wr_en, reg_rd_en, push_button_input, pin17_in, cnt_clr;
   logic supply_comparator_good, lcd_segment_nineteen, decimation_filter_clock;
   logic pin17_lcd_mode, pin17_out, pin17_oe, lcd_segment_nineteen_pin_out;
   logic timer_zero_clock_gate, timer_one_clock_gate;
   logic high_priority_io_interrupt, low_priority_io_interrupt;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rv;
   logic [15:0] pin_in, pin_out, pin_oe, pin_lcd_mode, ext_lvl;
   logic [1:0] pin_pair_in, pin_pair_lcd_mode, pin_pair_out, pin_pair_oe;
   logic [15:0] lfsr_state = 16'h1fdc;
   logic [15:0] rst_list [9] = '{OFS_DIR_MID, OFS_DIR_P17, OFS_DIR_LOW, OFS_CKOUT_SEL,
      OFS_ROUTE_0, OFS_ROUTE_1, OFS_ROUTE_2, OFS_ROUTE_3, 16'h0085};
   int cnt [4];
   int miscompares = 0;
   int total_checks = 0;

   dior_top dior_top_inst (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr_en, .reg_rd_en,
      .reg_rdata, .pin_in, .pin17_in, .pin_pair_in, .push_button_input, .pin_lcd_mode,
      .pin_pair_lcd_mode, .pin17_lcd_mode, .pin_out, .pin_oe, .pin17_out, .pin17_oe,
      .pin_pair_out, .pin_pair_oe, .supply_comparator_good, .lcd_segment_nineteen,
      .decimation_filter_clock, .lcd_segment_nineteen_pin_out, .timer_zero_clock_gate,
      .timer_one_clock_gate, .high_priority_io_interrupt, .low_priority_io_interrupt);
   dior_far_side dior_far_side_inst (.ref_clk, .cnt_clr, .pin_out, .pin_oe, .ext_lvl,
      .pin_in, .evt({low_priority_io_interrupt, high_priority_io_interrupt,
      timer_one_clock_gate, timer_zero_clock_gate}), .evt_count(cnt));

   // Free-running 100 MHz reference clock.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [7:0] rnd();
      lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12]
         ^ lfsr_state[10]};
      return lfsr_state[7:0];
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Both strobes drop for one edge after each access so no signal is set twice at once.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge ref_clk);
      reg_wr_en <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge ref_clk);
      reg_rd_en <= 1'b0;
      #1 d = reg_rdata;
      @(posedge ref_clk);
   endtask

   // Raise one source for len edges; 16 is the push button, a negative number only waits.
   task automatic pulse(input int src, input int len);
      if (src == 16) push_button_input <= 1'b1;
      else if (src >= 0) ext_lvl[src] <= 1'b1;
      repeat (len) @(posedge ref_clk);
      if (src == 16) push_button_input <= 1'b0;
      else if (src >= 0) ext_lvl[src] <= 1'b0;
   endtask

   task automatic route_run(input int s0, input int s1, input int ex [4]);
      cnt_clr <= 1'b1;
      @(posedge ref_clk);
      cnt_clr <= 1'b0;
      pulse(s0, 4);
      pulse(s1, 4);
      repeat (5) @(posedge ref_clk);
      #1;
      for (int j = 0; j < 4; j++) chk(8'(cnt[j]), 8'(ex[j]));
      @(posedge ref_clk);
   endtask

   // Model the data latch per port: a write lands only on output pins not in lcd use.
   task automatic port_run(input bit sel);
      logic [15:0] da, aa;
      logic [7:0] dirv, d, m, lcd8, lvl8, msk, dprev, exp, res, oe8, out8;
      da = sel ? OFS_DIR_MID : OFS_DIR_LOW;
      aa = sel ? OFS_DATA_MID : OFS_DATA_LOW;
      msk = sel ? 8'hff : 8'hfe;
      dprev = 8'h00;
      exp = 8'h00;
      for (int i = 0; i < 6; i++) begin
         lcd8 = rnd() & 8'h24;
         lvl8 = rnd();
         d = rnd();
         dirv = rnd();
         pin_lcd_mode <= sel ? {lcd8, pin_lcd_mode[7:0]} : {pin_lcd_mode[15:8], lcd8};
         ext_lvl <= sel ? {lvl8, ext_lvl[7:0]} : {ext_lvl[15:8], lvl8};
         push_button_input <= lvl8[0];
         wr(aa, d);
         m = dprev & ~lcd8 & msk;
         exp = (exp & ~m) | (d & m);
         wr(da, dirv);
         dprev = dirv;
         m = dirv & ~lcd8 & msk;
         rd(aa, rv);
         #1;
         oe8 = sel ? pin_oe[15:8] : pin_oe[7:0];
         out8 = sel ? pin_out[15:8] : pin_out[7:0];
         res = (m & exp) | (~m & lvl8);
         chk(oe8 & msk, m);
         chk(out8 & m, exp & m);
         chk(rv & ~lcd8 & msk, res & ~lcd8 & msk);
         if (!sel) chk(8'(rv[0]), 8'(lvl8[0]));
         @(posedge ref_clk);
      end
      rd(da, rv);
      chk(rv & msk, dprev & msk);
   endtask

   // Hang guard: a run that overstays its budget is failed.
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      $display("BAD t=%0t run did not finish", $time);
      tally_and_finish();
   end

   initial begin
      srst = 1'b1;
      {reg_wr_en, reg_rd_en, push_button_input, pin17_in, cnt_clr, pin17_lcd_mode} = '0;
      {supply_comparator_good, lcd_segment_nineteen, decimation_filter_clock} = '0;
      {reg_addr, reg_wdata, pin_lcd_mode, ext_lvl, pin_pair_in, pin_pair_lcd_mode} = '0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      #1 chk(pin_oe[15:8], 8'h00);
      chk(pin_oe[7:0], 8'h00);
      @(posedge ref_clk);
      port_run(1'b0);
      port_run(1'b1);
      pin_lcd_mode <= 16'h0000;
      wr(OFS_DIR_P17, 8'h02);
      wr(OFS_DATA_P17, 8'h02);
      #1 chk(8'({pin17_oe, pin17_out}), 8'h03);
      @(posedge ref_clk);
      pin17_lcd_mode <= 1'b1;
      @(posedge ref_clk);
      #1 chk(8'(pin17_oe), 8'h00);
      @(posedge ref_clk);
      pin17_lcd_mode <= 1'b0;
      wr(OFS_DIR_P17, 8'h01);
      #1 chk(8'(pin17_oe), 8'h00);
      @(posedge ref_clk);
      for (int k = 1; k < 4; k++) begin
         pin_pair_in <= 2'(k);
         pin17_in <= k[0];
         wr(OFS_DATA_HIGH, 8'(k << BIT_HIGH_PAIR));
         #1 chk(8'(pin_pair_out), 8'(k));
         chk(8'(pin_pair_oe), 8'h03);
         @(posedge ref_clk);
         rd(OFS_DATA_HIGH, rv);
         chk(rv, 8'(k << BIT_HIGH_PAIR));
         rd(OFS_DATA_P17, rv);
         chk(rv, k[0] ? 8'h02 : 8'h00);
      end
      // A pair pin in lcd use is released and keeps its latched data bit.
      pin_pair_lcd_mode <= 2'b01;
      wr(OFS_DATA_HIGH, 8'h00);
      #1 chk(8'({pin_pair_oe, pin_pair_out}), 8'h08);
      @(posedge ref_clk);
      pin_pair_lcd_mode <= 2'b00;
      for (int v = 0; v < 2; v++) begin
         supply_comparator_good <= v[0];
         wr(OFS_COMP_STAT, {7'h00, ~v[0]});
         rd(OFS_COMP_STAT, rv);
         chk(rv & 8'h01, 8'(v));
      end
      for (int s = 0; s < 2; s++) begin
         wr(OFS_CKOUT_SEL, s ? 8'h10 : 8'h00);
         for (int k = 0; k < 4; k++) begin
            {lcd_segment_nineteen, decimation_filter_clock} <= 2'(k);
            @(posedge ref_clk);
            #1 chk(8'(lcd_segment_nineteen_pin_out), 8'(s ? k % 2 : k / 2));
            @(posedge ref_clk);
         end
      end
      // Reset again in mid-run; the direction and clock-out select registers written above must read back zero.
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      {ext_lvl, push_button_input} <= '0;
      @(posedge ref_clk);
      for (int i = 0; i < 9; i++) begin
         rd(rst_list[i], rv);
         chk(rv, 8'h00);
      end
      wr(16'h0085, 8'hff);
      rd(16'h0085, rv);
      chk(rv, 8'h00);
      for (int c = 0; c < 8; c++) begin
         wr(OFS_ROUTE_0, 8'(c));
         route_run(16, -1, '{c == 2 ? 4 : 0, c == 3 ? 4 : 0, int'(c == 4 || c == 6),
            int'(c == 5 || c == 7)});
      end
      rd(OFS_ROUTE_0, rv);
      chk(rv & 8'h77, 8'h07);
      wr(OFS_ROUTE_1, 8'h72);
      rd(OFS_ROUTE_1, rv);
      chk(rv, 8'h02);
      wr(OFS_ROUTE_5, 8'h75);
      rd(OFS_ROUTE_5, rv);
      chk(rv, 8'h05);
      wr(OFS_ROUTE_0, 8'h02);
      wr(OFS_ROUTE_1, 8'h02);
      route_run(16, 2, '{8, 0, 0, 0});
      wr(OFS_ROUTE_2, 8'h40);
      route_run(4, 5, '{0, 0, 1, 0});
      tally_and_finish();
   end
endmodule
